// [src/pcm_ctrl_regs.sv]
`timescale 1ns/10ps
// What this block does
// - writes accepted only while control lock clear
// - primary regulator on by default, never written
// - protection may switch primary regulator off
// - primary regulator restarts when conditions met
// - power bit 5 enables external monitor B
// - power bit 4 enables external monitor A
// - monitor enables survive reset state entry
// - both registers reinit on reset entry
// - power bit 3 enables step-up, default 1
// - step-up enable cleared by fault or safe
// - power bit 1 enables secondary regulator
// - secondary enable cleared by fault or safe
// - clock bit 6 checks step-up clock
// - clock bit 4 checks secondary clock
// - clock bit 3 checks primary clock
// - clock bit 2 checks switching source clock
// - clock bit 1 checks sync input clock
module pcm_ctrl_regs (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_req_i, // register write command from the serial decoder
	input wire logic [0:0] sel_i, // register select
	input wire logic [pcm_pkg::REG_W-1:0] wr_data_i,
	output logic [pcm_pkg::REG_W-1:0] rd_data_o, // read data of selected register
	output logic wr_refused_o, // write dropped because lock was set
	input wire logic control_lock_i, // lock bit from device status
	input wire logic reset_state_entry_i, // one-cycle pulse on entering reset state
	input wire logic safe_state_entry_i, // one-cycle pulse on entering safe state
	input wire logic step_up_fault_i, // fault disabling step-up converter
	input wire logic secondary_fault_i, // fault disabling secondary regulator
	input wire logic primary_fault_i, // protection trip of primary regulator
	input wire logic primary_restart_ok_i, // primary restart conditions met
	input wire logic wake_i, // wake input level, already synchronised
	input wire logic wake_latch_i, // wake latch level
	input wire logic [1:0] strap_ext_i, // nonvolatile defaults for monitors B,A
	output logic primary_step_down_regulator_en_o,
	output logic secondary_regulator_enable_o,
	output logic step_up_enable_o,
	output logic external_monitor_a_enable_o,
	output logic external_monitor_b_enable_o,
	output logic step_up_clock_check_enable_o,
	output logic secondary_regulator_clock_check_enable_o,
	output logic primary_regulator_clock_check_enable_o,
	output logic switching_source_clock_check_enable_o,
	output logic sync_input_clock_check_enable_o
);
	import pcm_pkg::*;

	// how the bank behaves, in short
	// - two 8-bit control words, chosen by sel_i
	// - sel_i low picks power_control
	// - sel_i high picks clock_monitor_control
	// - a write lands on the edge that takes it
	// - read data follows the select at once
	// - read data always comes from the flops
	// - the lock input gates every host write
	// - a locked write changes nothing
	// - a locked write raises the refusal flag
	// - the refusal flag lasts as long as the request
	// - reserved bits have no writable path
	// - reserved bits therefore read as zero
	// - reinit beats hardware clear
	// - hardware clear beats a host write
	// - a host write beats holding
	//
	// power_control layout
	// - bit 5: external monitor b enable
	// - bit 4: external monitor a enable
	// - bit 3: step-up converter enable
	// - bit 1: secondary regulator enable
	// - bits 7:6, 2 and 0: reserved
	//
	// clock_monitor_control layout
	// - bit 6: step-up clock check
	// - bit 4: secondary regulator clock check
	// - bit 3: primary regulator clock check
	// - bit 2: switching source clock check
	// - bit 1: sync input clock check
	// - bits 7, 5 and 0: reserved
	//
	// start-up after power-on reset
	// - edge 1: strap pins reach the first stage
	// - edge 2: strap pins reach the second stage
	// - edge 3: strap values land in bits 5:4
	// - a host write to power_control at edge 3
	//   loses all its bits to the strap load
	// - hosts should wait three edges after release
	// - the clock word needs no strap and is ready
	//   from the first edge after release
	//
	// reset state entry
	// - a one-cycle pulse from the state machine
	// - clock word goes back to its defaults
	// - power word goes back, except bits 5:4
	// - bits 5:4 keep what software last chose
	// - only power-on reset reloads them from straps
	//
	// safe state entry and faults
	// - clear the step-up and secondary enables
	// - leave the monitor enables alone
	// - leave the clock checks alone
	// - software may set the enables again later
	// - a clear and a write in one cycle: clear wins
	//
	// primary regulator
	// - no register bit controls it
	// - wake pin or wake latch switch it on
	// - protection trips it off at the next edge
	// - it returns once restart is allowed
	//   and no fault is pending
	// - a pending fault holds it tripped
	//
	// register cells
	// - one cell per word, same logic in both
	// - a write carrier brings strobe, data, mask
	// - the mask keeps reserved bits out
	// - the keep mask guards bits over reinit
	// - the hardware clear vector is per bit
	//
	// write path
	// - the serial decoder hands over one strobe
	// - the select picks the target cell
	// - the lock blocks both cells alike
	// - the strap load borrows the power carrier
	//   with its own mask, so only bits 5:4 move
	//
	// limitations
	// - a reset state pulse in the strap load cycle
	//   keeps the old bits 5:4, not the straps
	// - fault inputs are taken as synchronous levels
	// - wake inputs must already be synchronised
	// - the refusal flag is combinational
	// - no read side effects in either word
	//
	// checks at the bottom
	// - lock, reinit, keep, clears, restart
	// - masked writes on both words
	// - words hold when nothing acts on them
	// - straps reach bits 5:4 after release

	// write carriers for each register
	pcm_wr_if pc_wr ();
	pcm_wr_if cm_wr ();

	// write gating by lock
	wire logic wr_ok = wr_req_i && !control_lock_i;
	assign wr_refused_o = wr_req_i && control_lock_i;

	// strap capture after power-on reset
	wire logic strap_load;
	wire logic [1:0] strap_sync;
	pcm_strap_load u_strap (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.strap_i(strap_ext_i),
		.load_o(strap_load),
		.strap_o(strap_sync)
	);

	// keep mask: monitor enables hold over reset state entry
	localparam logic [7:0] PC_KEEP = 8'h30;
	wire logic [7:0] strap_word = {2'h0, strap_sync, 4'h0};

	// hardware clears of enables
	wire logic [7:0] pc_clr;
	assign pc_clr = {4'h0, step_up_fault_i || safe_state_entry_i,
		1'b0, secondary_fault_i || safe_state_entry_i, 1'b0};

	// strap load uses the write path with forced unlock
	wire logic pc_sel_wr = wr_ok && (sel_i == SEL_POWER);
	wire logic cm_sel_wr = wr_ok && (sel_i == SEL_CLKMON);
	assign pc_wr.wr_en = pc_sel_wr || strap_load;
	assign pc_wr.wr_data = strap_load ? strap_word : wr_data_i;
	assign pc_wr.wr_mask = strap_load ? PC_KEEP : PC_WR_MASK;
	assign cm_wr.wr_en = cm_sel_wr;
	assign cm_wr.wr_data = wr_data_i;
	assign cm_wr.wr_mask = CM_WR_MASK;

	wire logic [7:0] pc_q;
	wire logic [7:0] cm_q;

	// power control register
	pcm_reg_cell #(.RESET_VAL(PC_RESET), .KEEP_MASK(PC_KEEP)) u_pc (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.reinit_i(reset_state_entry_i),
		.keep_val_i(strap_word),
		.hw_clr_i(pc_clr),
		.wr(pc_wr),
		.q_o(pc_q)
	);

	// clock monitor control register
	pcm_reg_cell #(.RESET_VAL(CM_RESET), .KEEP_MASK(8'h00)) u_cm (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.reinit_i(reset_state_entry_i),
		.keep_val_i(8'h00),
		.hw_clr_i(8'h00),
		.wr(cm_wr),
		.q_o(cm_q)
	);

	// read mux, reserved bits already zero
	assign rd_data_o = (sel_i == SEL_POWER) ? pc_q : cm_q;

	// field outputs
	assign external_monitor_b_enable_o = pc_q[PC_EXT_B_BIT];
	assign external_monitor_a_enable_o = pc_q[PC_EXT_A_BIT];
	assign step_up_enable_o = pc_q[PC_STEP_UP_BIT];
	assign secondary_regulator_enable_o = pc_q[PC_SEC_REG_BIT];
	assign step_up_clock_check_enable_o = cm_q[CM_STEP_UP_BIT];
	assign secondary_regulator_clock_check_enable_o = cm_q[CM_SEC_REG_BIT];
	assign primary_regulator_clock_check_enable_o = cm_q[CM_PRI_REG_BIT];
	assign switching_source_clock_check_enable_o = cm_q[CM_SOURCE_BIT];
	assign sync_input_clock_check_enable_o = cm_q[CM_SYNC_IN_BIT];

	// primary regulator trip state, never touched by writes
	pcm_pri_e pri_ff;
	pcm_pri_e nxt_pri;
	always_comb begin
		nxt_pri = pri_ff;
		case (pri_ff)
			PCM_PRI_ON: begin
				if (primary_fault_i) begin
					nxt_pri = PCM_PRI_TRIPPED;
				end
			end
			PCM_PRI_TRIPPED: begin
				if (primary_restart_ok_i && !primary_fault_i) begin
					nxt_pri = PCM_PRI_ON;
				end
			end
			default: begin
				nxt_pri = PCM_PRI_ON;
			end
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pri_ff <= PCM_PRI_ON;
		end else begin
			pri_ff <= nxt_pri;
		end
	end
	// on by default; only wake and its latch or protection switch it
	assign primary_step_down_regulator_en_o = (wake_i || wake_latch_i) &&
		(pri_ff == PCM_PRI_ON);

	// checks
	a_lock_blocks_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr_req_i && control_lock_i && !strap_load && !reset_state_entry_i &&
		!safe_state_entry_i && !step_up_fault_i && !secondary_fault_i)
		|=> ($stable(pc_q) || sel_i != SEL_POWER) && ($stable(cm_q) || sel_i != SEL_CLKMON))
		else $error("locked write changed a register");
	a_reinit_values: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		reset_state_entry_i |=> (cm_q == CM_RESET) && ((pc_q & ~PC_KEEP) == PC_RESET))
		else $error("reset state entry did not reinit registers");
	a_keep_monitors: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		reset_state_entry_i && !strap_load |=> pc_q[5:4] == $past(pc_q[5:4]))
		else $error("monitor enables lost on reset state entry");
	a_safe_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		safe_state_entry_i && !reset_state_entry_i |=> !pc_q[PC_SEC_REG_BIT] && !pc_q[PC_STEP_UP_BIT])
		else $error("safe entry left regulator enables set");
	a_fault_clear_up: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		step_up_fault_i && !reset_state_entry_i |=> !step_up_enable_o)
		else $error("step-up fault did not clear enable");
	a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		((pc_q & ~PC_WR_MASK) == 8'h00) && ((cm_q & ~CM_WR_MASK) == 8'h00))
		else $error("reserved bit set");
	a_trip_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		primary_fault_i |=> !primary_step_down_regulator_en_o)
		else $error("primary regulator not tripped");
	// restart allowed while tripped and no fault pending
	sequence s_restart_met;
		(pri_ff == PCM_PRI_TRIPPED) && primary_restart_ok_i && !primary_fault_i;
	endsequence
	// a wake source one cycle later must see the regulator on
	sequence s_wake_after;
		##1 (wake_i || wake_latch_i);
	endsequence
	a_restart_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_restart_met ##0 s_wake_after |-> primary_step_down_regulator_en_o)
		else $error("primary regulator did not restart");
	a_write_lands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cm_sel_wr && !reset_state_entry_i |=> cm_q == ($past(wr_data_i) & CM_WR_MASK))
		else $error("clock monitor write lost");
	// an unlocked power write lands masked when nothing outranks it
	a_pc_write_lands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		pc_sel_wr && !strap_load && !reset_state_entry_i && !safe_state_entry_i &&
		!step_up_fault_i && !secondary_fault_i |=> pc_q == ($past(wr_data_i) & PC_WR_MASK))
		else $error("power control write lost");
	// the strap load puts the synchronised pins into bits 5:4
	a_strap_loads: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		strap_load && !reset_state_entry_i |=> pc_q[5:4] == $past(strap_sync))
		else $error("strap values not loaded");
	// a secondary fault clears its enable
	a_fault_clear_sec: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		secondary_fault_i && !reset_state_entry_i |=> !secondary_regulator_enable_o)
		else $error("secondary fault did not clear enable");
	// safe state entry clears the step-up enable
	a_safe_clears_up: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		safe_state_entry_i && !reset_state_entry_i |=> !step_up_enable_o)
		else $error("safe entry left step-up enable set");
	// with neither wake source the primary stays off
	a_pri_needs_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!wake_i && !wake_latch_i |-> !primary_step_down_regulator_en_o)
		else $error("primary regulator on without wake");
	// only a fault can move the primary out of its on state
	a_pri_write_free: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pri_ff == PCM_PRI_ON) && !primary_fault_i |=> pri_ff == PCM_PRI_ON)
		else $error("primary regulator left on state without fault");
	// the clock word moves only by write or reinit
	a_cm_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!cm_sel_wr && !reset_state_entry_i |=> $stable(cm_q))
		else $error("clock monitor word changed without cause");
	// the power word moves only by write, strap, clear or reinit
	a_pc_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!pc_wr.wr_en && !reset_state_entry_i && (pc_clr == 8'h00) |=> $stable(pc_q))
		else $error("power word changed without cause");
	// reinit turns the sync input check off
	a_sync_check_reinit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		reset_state_entry_i |=> !sync_input_clock_check_enable_o)
		else $error("sync input check left on after reinit");
endmodule // pcm_ctrl_regs

// [common/pcm_pkg.sv]
package pcm_pkg;
	// register width
	localparam int REG_W = 8;
	// register select codes seen on the command port
	localparam logic [0:0] SEL_POWER = 1'h0;
	localparam logic [0:0] SEL_CLKMON = 1'h1;
	// power_control field positions
	localparam int PC_EXT_B_BIT = 5;
	localparam int PC_EXT_A_BIT = 4;
	localparam int PC_STEP_UP_BIT = 3;
	localparam int PC_SEC_REG_BIT = 1;
	// clock_monitor_control field positions
	localparam int CM_STEP_UP_BIT = 6;
	localparam int CM_SEC_REG_BIT = 4;
	localparam int CM_PRI_REG_BIT = 3;
	localparam int CM_SOURCE_BIT = 2;
	localparam int CM_SYNC_IN_BIT = 1;
	// writable bit masks, reserved bits excluded
	localparam logic [7:0] PC_WR_MASK = 8'h3a;
	localparam logic [7:0] CM_WR_MASK = 8'h5e;
	// reset values with the strap-loaded bits at zero
	localparam logic [7:0] PC_RESET = 8'h0a;
	localparam logic [7:0] CM_RESET = 8'h5c;
	// lifecycle of the power path
	typedef enum logic [1:0] {
		PCM_PRI_ON = 2'b00,
		PCM_PRI_TRIPPED = 2'b01
	} pcm_pri_e;
endpackage

// [common/pcm_wr_if.sv]
`timescale 1ns/10ps
// write request carried from the top module to the register cell
interface pcm_wr_if;
	logic wr_en; // accepted write strobe
	logic [7:0] wr_data; // written value
	logic [7:0] wr_mask; // bits that software may change
	modport src (output wr_en, output wr_data, output wr_mask);
	modport dst (input wr_en, input wr_data, input wr_mask);
endinterface

// [src/pcm_reg_cell.sv]
`timescale 1ns/10ps
// one control register: masked write, hardware clear, reinit and keep mask
module pcm_reg_cell #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] KEEP_MASK = 8'h00
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic reinit_i,
	input wire logic [7:0] keep_val_i,
	input wire logic [7:0] hw_clr_i,
	pcm_wr_if.dst wr,
	output logic [7:0] q_o
);
	logic [7:0] q_ff;
	logic [7:0] nxt_q;
	wire logic [7:0] wr_val = (q_ff & ~wr.wr_mask) | (wr.wr_data & wr.wr_mask);
	wire logic [7:0] base = wr.wr_en ? wr_val : q_ff;
	wire logic [7:0] init_val = (RESET_VAL & ~KEEP_MASK) | (q_ff & KEEP_MASK);
	// reinit wins, then hardware clear over write
	assign nxt_q = reinit_i ? init_val : (base & ~hw_clr_i);
	// power-on reset loads reset value; keep bits then come from strap
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q_ff <= RESET_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign q_o = q_ff;
	// keep value port is not used by the cell; kept bits come from q_ff
	logic unused_keep;
	assign unused_keep = ^keep_val_i;
endmodule // pcm_reg_cell

// [src/pcm_strap_load.sv]
`timescale 1ns/10ps
// captures strap levels once after power-on reset release
module pcm_strap_load (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] strap_i,
	output logic load_o,
	output logic [1:0] strap_o
);
	logic [1:0] s1_ff;
	logic [1:0] s2_ff;
	logic [2:0] seen_ff; // release history, one bit per edge since release
	// two-stage synchroniser; the load waits until the second stage holds the pins
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_ff <= 2'h0;
			s2_ff <= 2'h0;
			seen_ff <= 3'h0;
		end else begin
			s1_ff <= strap_i;
			s2_ff <= s1_ff;
			seen_ff <= {seen_ff[1:0], 1'b1};
		end
	end
	// one pulse in the first cycle that the second stage holds the pins
	assign load_o = seen_ff[1] && !seen_ff[2];
	assign strap_o = s2_ff;
endmodule // pcm_strap_load

// [sim/pcm_host_model.sv]
`timescale 1ns/10ps
// host side of the serial command path: issues register writes and reads
module pcm_host_model (
	input wire logic core_clk_i,
	input wire logic [7:0] rd_data_i, // read data of the selected register
	input wire logic wr_refused_i, // refusal flag from the block
	output logic wr_req_o, // write command strobe
	output logic [0:0] sel_o, // register select
	output logic [7:0] wr_data_o // write data, scrambled while idle
);
	// idle levels from time zero
	initial begin
		wr_req_o = 1'b0;
		sel_o = 1'b0;
		wr_data_o = 8'h00;
	end
	// one write held across one edge; refusal sampled mid-cycle
	task automatic write(input logic [0:0] sel, input logic [7:0] data, output logic refused);
		@(posedge core_clk_i);
		#1;
		wr_req_o = 1'b1;
		sel_o = sel;
		wr_data_o = data;
		#2;
		refused = wr_refused_i;
		@(posedge core_clk_i);
		#1;
		wr_req_o = 1'b0;
		wr_data_o = ~data; // an idle data bus does not keep its last value
	endtask
	// select a register and return its read value
	task automatic read(input logic [0:0] sel, output logic [7:0] data);
		@(posedge core_clk_i);
		#1;
		sel_o = sel;
		#2;
		data = rd_data_i;
	endtask
endmodule // pcm_host_model

// [sim/pcm_ctrl_regs_tb.sv]
`timescale 1ns/10ps
// self-checking bench of the control register bank
module pcm_ctrl_regs_tb;
	import pcm_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, wr_req, refused, lock = 1'b0, rse = 1'b0, sse = 1'b0;
	logic su_f = 1'b0, sec_f = 1'b0, pri_f = 1'b0, rst_ok = 1'b0, wake = 1'b1, wlatch = 1'b0;
	logic [0:0] sel;
	logic [7:0] wr_data, rd_data;
	logic [1:0] strap = 2'b10; // monitor b on, monitor a off
	logic pri_en, sec_en, su_en, a_en, b_en, su_ck, sec_ck, pri_ck, src_ck, sync_ck;
	int err_count = 0;
	int n_compared = 0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	pcm_ctrl_regs u_pcm_ctrl_regs (.core_clk_i(clk), .rst_n_i(rst_n), .wr_req_i(wr_req),
		.sel_i(sel), .wr_data_i(wr_data), .rd_data_o(rd_data), .wr_refused_o(refused),
		.control_lock_i(lock), .reset_state_entry_i(rse), .safe_state_entry_i(sse),
		.step_up_fault_i(su_f), .secondary_fault_i(sec_f), .primary_fault_i(pri_f),
		.primary_restart_ok_i(rst_ok), .wake_i(wake), .wake_latch_i(wlatch),
		.strap_ext_i(strap), .primary_step_down_regulator_en_o(pri_en),
		.secondary_regulator_enable_o(sec_en), .step_up_enable_o(su_en),
		.external_monitor_a_enable_o(a_en), .external_monitor_b_enable_o(b_en),
		.step_up_clock_check_enable_o(su_ck), .secondary_regulator_clock_check_enable_o(sec_ck),
		.primary_regulator_clock_check_enable_o(pri_ck),
		.switching_source_clock_check_enable_o(src_ck), .sync_input_clock_check_enable_o(sync_ck));
	pcm_host_model u_pcm_host_model (.core_clk_i(clk), .rd_data_i(rd_data),
		.wr_refused_i(refused), .wr_req_o(wr_req), .sel_o(sel), .wr_data_o(wr_data));
	// verdict and end of run
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one comparison, reported at once on mismatch
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// reads both registers and compares them and the enable outputs
	task automatic chk_regs(input logic [7:0] pc, input logic [7:0] cm);
		logic [7:0] v;
		u_pcm_host_model.read(SEL_POWER, v);
		chk(v, pc, "power register");
		u_pcm_host_model.read(SEL_CLKMON, v);
		chk(v, cm, "clock register");
		chk({b_en, a_en, su_en, sec_en}, {pc[5:3], pc[1]}, "power enables");
		chk({su_ck, sec_ck, pri_ck, src_ck, sync_ck}, {cm[6], cm[4:1]}, "clock checks");
	endtask
	// write and compare the refusal flag
	task automatic wr(input logic [0:0] s, input logic [7:0] d, input logic exp_ref);
		logic r;
		u_pcm_host_model.write(s, d, r);
		chk({7'h0, r}, {7'h0, exp_ref}, "refusal flag");
	endtask
	// one-cycle pulse on an event input: 0 reset, 1 safe, 2 step-up, 3 secondary, 4 primary
	task automatic pulse(input int k);
		@(posedge clk);
		#1;
		case (k)
			0: rse = 1'b1;
			1: sse = 1'b1;
			2: su_f = 1'b1;
			3: sec_f = 1'b1;
			default: pri_f = 1'b1;
		endcase
		@(posedge clk);
		#1;
		{rse, sse, su_f, sec_f, pri_f} = 5'h0;
	endtask
	// defaults after power-on reset, monitor enables from straps
	task automatic t_defaults();
		chk_regs(8'h2a, 8'h5c);
	endtask
	// locked writes are dropped and flagged; the lock is cleared afterwards
	task automatic t_lock();
		lock = 1'b1;
		wr(SEL_POWER, 8'h00, 1'b1);
		wr(SEL_CLKMON, 8'h00, 1'b1);
		chk_regs(8'h2a, 8'h5c);
		lock = 1'b0;
	endtask
	// walking ones then all ones: reserved bits read zero
	task automatic t_bits();
		for (int i = 0; i < 8; i++) begin
			wr(SEL_POWER, 8'h01 << i, 1'b0);
			wr(SEL_CLKMON, 8'h01 << i, 1'b0);
			chk_regs((8'h01 << i) & 8'h3a, (8'h01 << i) & 8'h5e);
		end
		wr(SEL_POWER, 8'hff, 1'b0);
		wr(SEL_CLKMON, 8'hff, 1'b0);
		chk_regs(8'h3a, 8'h5e);
	endtask
	// reset-state entry reinitialises all but the monitor enables
	task automatic t_reset_entry();
		wr(SEL_POWER, 8'h10, 1'b0);
		wr(SEL_CLKMON, 8'h00, 1'b0);
		pulse(0);
		chk_regs(8'h1a, 8'h5c);
	endtask
	// safe-state entry and faults clear regulator enables
	task automatic t_clears();
		wr(SEL_POWER, 8'h3a, 1'b0);
		pulse(1);
		chk_regs(8'h30, 8'h5c);
		wr(SEL_POWER, 8'h3a, 1'b0);
		pulse(2);
		chk_regs(8'h32, 8'h5c);
		pulse(3);
		chk_regs(8'h30, 8'h5c);
		// a fault clear and a write on the same edge: the clear wins
		fork
			wr(SEL_POWER, 8'h3a, 1'b0);
			pulse(2);
		join
		chk_regs(8'h32, 8'h5c);
	endtask
	// primary regulator: wake control, protection trip, restart
	task automatic t_primary();
		chk({7'h0, pri_en}, 8'h01, "primary on by wake");
		pulse(4);
		chk({7'h0, pri_en}, 8'h00, "primary tripped");
		wr(SEL_POWER, 8'hff, 1'b0);
		chk({7'h0, pri_en}, 8'h00, "primary not writable");
		rst_ok = 1'b1;
		@(posedge clk);
		#1;
		chk({7'h0, pri_en}, 8'h01, "primary restarted");
		wake = 1'b0;
		wlatch = 1'b1;
		@(posedge clk);
		#1;
		chk({7'h0, pri_en}, 8'h01, "primary on by latch");
		wlatch = 1'b0;
		@(posedge clk);
		#1;
		chk({7'h0, pri_en}, 8'h00, "primary off by wake");
	endtask
	// power-on reset in mid-run: defaults return, monitor enables from new straps
	task automatic t_por();
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		strap = 2'b01; // monitor a on, monitor b off
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({7'h0, pri_en}, 8'h00, "primary off without wake");
		chk_regs(8'h1a, 8'h5c);
		wake = 1'b1;
		#1;
		chk({7'h0, pri_en}, 8'h01, "primary on after reset");
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		t_defaults();
		t_lock();
		t_bits();
		t_reset_entry();
		t_clears();
		t_primary();
		t_por();
		complete_run();
	end
	// watchdog against a hang
	initial begin
		#20000;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end
endmodule // pcm_ctrl_regs_tb
